// ===== hw/uwm_defines.vh
/*
  Shared constants of the serial transceiver: register indices, field
  positions, reset values, identification codes and tick counts.
  Assumes inclusion by bare name from every design file that needs them.
*/
// Notes on behaviour
// - Divisor select bit redirects the two lowest registers to the divisor bytes.
// - Reading the data port pops the oldest received entry unless divisor selected.
// - A transmit write into a full queue is dropped, contents unchanged.
// - Interrupt mask bits gate data, holding empty, line status, modem sources.
// - Bit timing uses sixteen sampling ticks per serial bit.
// - FIFO control bit 0 enables queues; bits 1 and 2 flush receive, transmit.
// - Transmit empty trigger: empty, two characters, quarter or half full.
// - Receive trigger: one character, quarter full or half full.
// - Receive trigger code 11 means two entries below full.
// - Identification bit 0 high when idle; bits 3:1 name the source.
// - Line control bit 3 adds parity; bit 4 picks even, else odd.
// - Stop select gives one, one and a half for five bits, or two.
// - Length field selects five to eight data bits; line control resets 0x03.
// - Modem control bit 5 turns on automatic request and clear to send.
// - Loopback ties serial out to in, pad high, modem outputs to inputs.
// - Request and ready control bits drive their pins inverted.
// - Transmitter idle flag needs empty queue and shifter; clears on write.
// - Queue empty flag clears on write and raises the holding empty interrupt.
// - Framing, parity, overrun flags raise line status interrupt, clear on read.
// - Line status shows data ready, receive queue error and break.
// - Modem status upper bits show inverted inputs, or looped outputs.
// - Delta bits latch changes and ring rising edge; all clear on read.
`ifndef UWM_DEFINES_VH
`define UWM_DEFINES_VH
// Register indices; byte address is four times the index
`define UWM_IDX_DATA 8'h00
`define UWM_IDX_IER 8'h02
`define UWM_IDX_FCR 8'h04
`define UWM_IDX_LCR 8'h06
`define UWM_IDX_MCR 8'h08
`define UWM_IDX_LSR 8'h0a
`define UWM_IDX_MSR 8'h0c
`define UWM_IDX_USR 8'h0e
`define UWM_IDX_TFL 8'h10
`define UWM_IDX_RFL 8'h12
`define UWM_LCR_RESET 8'h03
// Line control fields
`define UWM_LCR_DIVSEL 7
`define UWM_LCR_BREAK 6
`define UWM_LCR_EVEN 4
`define UWM_LCR_PAREN 3
`define UWM_LCR_STOP 2
// Modem control fields
`define UWM_MCR_AUTO 5
`define UWM_MCR_LOOP 4
`define UWM_USER_OUTPUT_TWO 3
`define UWM_USER_OUTPUT_ONE 2
`define UWM_REQUEST_TO_SEND_CTL 1
`define UWM_TERMINAL_READY_CTL 0
// Interrupt mask fields
`define UWM_IER_RXDATA 0
`define UWM_IER_THOLD 1
`define UWM_IER_LINE 2
`define UWM_IER_MODEM 3
`define UWM_IER_PROG 7
// Identification codes
`define UWM_ID_LINE 3'b110
`define UWM_ID_RXDATA 3'b010
`define UWM_ID_THOLD 3'b001
`define UWM_ID_MODEM 3'b000
// Tick counts
`define UWM_TICKS_PER_BIT 16
`define UWM_STOP_ONE 6'd16
`define UWM_STOP_HALF 6'd24
`define UWM_STOP_TWO 6'd32
`define UWM_RX_MID 4'd7
`define UWM_RX_TMO_TICKS 10'd640
`endif

// ===== hw/uwm_fifo.v
/*
  Character queue with registered read data showing the oldest entry.
  Pops from an empty queue are ignored; pushes into a full queue drop.
*/
`default_nettype none
module uwm_fifo #(
  parameter W = 8,
  parameter AW = 5
) (
  input wire clk,
  input wire rst_n,
  input wire clr,
  input wire push,
  input wire [W-1:0] wdata,
  input wire pop,
  output reg [W-1:0] rdata,
  output reg [AW:0] count
);
  localparam [AW:0] DEPTH = 1 << AW;
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  wire push_ok = push & ~clr & (count != DEPTH);
  wire pop_ok = pop & ~clr & (count != {(AW+1){1'b0}});
  wire [AW-1:0] rp_nxt = clr ? {AW{1'b0}} : (pop_ok ? rp_r + 1'b1 : rp_r);

  ////////////////////////////////////////////////////////////////////////
  // Storage write
  always @(posedge clk) begin
    if (push_ok) begin
      mem[wp_r] <= wdata;
    end
  end

  // Pointers, occupancy and head register with write bypass
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      rdata <= {W{1'b0}};
    end else begin
      rp_r <= rp_nxt;
      if (clr) begin
        wp_r <= {AW{1'b0}};
        count <= {(AW+1){1'b0}};
      end else begin
        if (push_ok) begin
          wp_r <= wp_r + 1'b1;
        end
        count <= count + {{AW{1'b0}}, push_ok} - {{AW{1'b0}}, pop_ok};
      end
      if (push_ok && (wp_r == rp_nxt)) begin
        rdata <= wdata;
      end else begin
        rdata <= mem[rp_nxt];
      end
    end
  end
endmodule
`default_nettype wire

// ===== hw/uwm_tx.v
/*
  Transmit shifter: start bit, five to eight data bits, optional parity,
  one, one and a half or two stop bits, each bit sixteen ticks long.
  Assumes start is a one-cycle pulse given only while busy is low.
*/
`include "uwm_defines.vh"
`default_nettype none
module uwm_tx (
  input wire clk,
  input wire rst_n,
  input wire tick,
  input wire start,
  input wire [7:0] data,
  input wire [1:0] char_len,
  input wire par_en,
  input wire par_even,
  input wire stop_long,
  input wire brk,
  output wire txd,
  output wire busy
);
  localparam S_IDLE = 2'd0;
  localparam S_BITS = 2'd1;
  localparam S_STOP = 2'd2;
  reg [1:0] st_r;
  reg [10:0] sh_r;
  reg [3:0] left_r;
  reg [5:0] tcnt_r;
  wire [7:0] dmask = data & (8'hff >> (2'd3 - char_len));
  wire pbit = par_even ? ^dmask : ~^dmask;
  wire [3:0] pos = {2'b00, char_len} + 4'd5;
  wire [9:0] ponehot = (par_en & pbit) ? (10'h001 << pos) : 10'h000;
  wire [10:0] frame = {{2'b00, dmask} | ponehot, 1'b0};
  wire [3:0] nbits = {2'b00, char_len} + 4'd6 + {3'b000, par_en};
  // Stop length in ticks
  wire [5:0] stop_ticks = !stop_long ? `UWM_STOP_ONE :
                          (char_len == 2'b00) ? `UWM_STOP_HALF : `UWM_STOP_TWO;

  assign busy = (st_r != S_IDLE);
  // Break forces the line low
  assign txd = ((st_r == S_BITS) ? sh_r[0] : 1'b1) & ~brk;

  ////////////////////////////////////////////////////////////////////////
  // Frame sequencer
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= S_IDLE;
      sh_r <= 11'h7ff;
      left_r <= 4'd0;
      tcnt_r <= 6'd0;
    end else begin
      case (st_r)
        S_IDLE: begin
          if (start) begin
            sh_r <= frame;
            left_r <= nbits;
            tcnt_r <= 6'd0;
            st_r <= S_BITS;
          end
        end
        S_BITS: begin
          if (tick) begin
            tcnt_r <= tcnt_r + 6'd1;
            if (tcnt_r == `UWM_TICKS_PER_BIT - 1) begin
              tcnt_r <= 6'd0;
              sh_r <= {1'b1, sh_r[10:1]};
              left_r <= left_r - 4'd1;
              if (left_r == 4'd1) begin
                st_r <= S_STOP;
              end
            end
          end
        end
        S_STOP: begin
          if (tick) begin
            tcnt_r <= tcnt_r + 6'd1;
            if (tcnt_r == stop_ticks - 6'd1) begin
              st_r <= S_IDLE;
            end
          end
        end
        default: begin
          st_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== hw/uwm_core.v
/*
  Serial transceiver with modem control: APB register slave, baud tick
  generator, receiver, transmit and receive queues, modem status.
  Assumes serial and modem inputs are synchronous to pclk; APB answers
  with no wait state.
*/
`include "uwm_defines.vh"
`default_nettype none
module uwm_core #(
  parameter AW = 5
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire serial_in,
  output wire serial_out_pad,
  input wire cts_n,
  input wire dsr_n,
  input wire dcd_n,
  input wire ri_n,
  output wire rts_n,
  output wire dtr_n,
  output wire out1_n,
  output wire out2_n
);
  localparam [AW:0] DEPTH = 1 << AW;
  localparam [AW:0] QUARTER = DEPTH >> 2;
  localparam [AW:0] HALF = DEPTH >> 1;
  localparam [AW:0] ZERO = 0;
  localparam [AW:0] ONE = 1;
  localparam [AW:0] TWO = 2;
  localparam R_IDLE = 2'd0;
  localparam R_START = 2'd1;
  localparam R_BITS = 2'd2;
  localparam R_STOP = 2'd3;

  reg [7:0] dll_r;
  reg [7:0] dlh_r;
  reg [7:0] ier_r;
  reg [7:0] lcr_r;
  reg [5:0] mcr_r;
  reg fifo_en_r;
  reg [1:0] ttrig_r;
  reg [1:0] rtrig_r;
  reg [7:0] prdata_r;
  reg [15:0] bcnt_r;
  reg oe_r;
  reg pe_r;
  reg fe_r;
  reg bi_r;
  reg rx_err_r;
  reg [3:0] mprev_r;
  reg [3:0] delta_r;
  reg mseen_r;
  reg rts_flow_r;
  reg [1:0] rs_r;
  reg [3:0] rtc_r;
  reg [3:0] rbit_r;
  reg [8:0] rsh_r;
  reg rx_hi_r;
  reg [9:0] tmo_cnt_r;
  reg tmo_r;
  reg rts_n_r;
  reg dtr_n_r;
  reg out1_n_r;
  reg out2_n_r;
  reg sout_r;
  reg [7:0] rmux;
  reg [2:0] id_code;
  reg id_none;

  ////////////////////////////////////////////////////////////////////////
  // APB decode
  wire [7:0] idx = paddr[9:2];
  wire hit = (paddr[11:10] == 2'b00) && (idx == `UWM_IDX_DATA || idx == `UWM_IDX_IER ||
             idx == `UWM_IDX_FCR || idx == `UWM_IDX_LCR || idx == `UWM_IDX_MCR ||
             idx == `UWM_IDX_LSR || idx == `UWM_IDX_MSR || idx == `UWM_IDX_USR ||
             idx == `UWM_IDX_TFL || idx == `UWM_IDX_RFL);
  wire setup = psel & ~penable;
  wire wr = psel & penable & pwrite & hit;
  wire rd = psel & penable & ~pwrite & hit;
  wire divsel = lcr_r[`UWM_LCR_DIVSEL];
  wire loop = mcr_r[`UWM_MCR_LOOP];
  wire afce = mcr_r[`UWM_MCR_AUTO];
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata = {24'h000000, prdata_r};

  // Queue wiring
  wire [10:0] rx_head;
  wire [7:0] tx_head;
  wire [AW:0] rx_cnt;
  wire [AW:0] tx_cnt;
  wire rx_push;
  wire tx_busy;
  wire txd;
  wire tick;
  wire fcr_wr = wr && (idx == `UWM_IDX_FCR);
  wire rx_clr = fcr_wr & pwdata[1];
  wire tx_clr = fcr_wr & pwdata[2];
  wire rx_pop = rd && (idx == `UWM_IDX_DATA) && !divsel;
  // Queue of one entry while queues are off
  wire rx_full = fifo_en_r ? (rx_cnt == DEPTH) : (rx_cnt != ZERO);
  wire tx_full = fifo_en_r ? (tx_cnt == DEPTH) : (tx_cnt != ZERO);
  wire tx_push = wr && (idx == `UWM_IDX_DATA) && !divsel && !tx_full;

  // Modem state, inverted pins or looped outputs
  wire [3:0] mstate = loop ? {mcr_r[`UWM_USER_OUTPUT_TWO], mcr_r[`UWM_USER_OUTPUT_ONE],
                              mcr_r[`UWM_TERMINAL_READY_CTL], mcr_r[`UWM_REQUEST_TO_SEND_CTL]} :
                             {~dcd_n, ~ri_n, ~dsr_n, ~cts_n};
  wire cts_ok = ~afce | mstate[0];
  wire tx_start = ~tx_busy & (tx_cnt != ZERO) & cts_ok;
  wire rx_in = loop ? txd : serial_in;

  ////////////////////////////////////////////////////////////////////////
  // Trigger levels
  wire [AW:0] tx_lvl = (ttrig_r == 2'b00) ? ZERO : (ttrig_r == 2'b01) ? TWO :
                       (ttrig_r == 2'b10) ? QUARTER : HALF;
  wire [AW:0] rx_lvl = (rtrig_r == 2'b00) ? ONE : (rtrig_r == 2'b01) ? QUARTER :
                       (rtrig_r == 2'b10) ? HALF : DEPTH - TWO;
  wire rx_hit = fifo_en_r ? (rx_cnt >= rx_lvl) : (rx_cnt != ZERO);
  wire tq_empty = (tx_cnt == ZERO);
  wire tx_idle = tq_empty & ~tx_busy;
  wire tx_hold_empty_cond = (ier_r[`UWM_IER_PROG] & fifo_en_r) ? (tx_cnt <= tx_lvl) : tq_empty;
  wire line_int = oe_r | pe_r | fe_r | bi_r;

  // Identification with fixed priority
  always @* begin
    id_none = 1'b0;
    id_code = `UWM_ID_MODEM;
    if (ier_r[`UWM_IER_LINE] && line_int) begin
      id_code = `UWM_ID_LINE;
    end else if (ier_r[`UWM_IER_RXDATA] && (rx_hit || tmo_r)) begin
      id_code = `UWM_ID_RXDATA;
    end else if (ier_r[`UWM_IER_THOLD] && tx_hold_empty_cond) begin
      id_code = `UWM_ID_THOLD;
    end else if (ier_r[`UWM_IER_MODEM] && (delta_r != 4'h0)) begin
      id_code = `UWM_ID_MODEM;
    end else begin
      id_none = 1'b1;
    end
  end

  // Read multiplexer
  always @* begin
    rmux = 8'h00;
    case (idx)
      `UWM_IDX_DATA: rmux = divsel ? dll_r : rx_head[7:0];
      `UWM_IDX_IER: rmux = divsel ? dlh_r : ier_r;
      `UWM_IDX_FCR: rmux = {4'h0, id_code, id_none};
      `UWM_IDX_LCR: rmux = lcr_r;
      `UWM_IDX_MCR: rmux = {2'b00, mcr_r};
      `UWM_IDX_LSR: rmux = {rx_err_r, tx_idle, tq_empty, bi_r, fe_r, pe_r, oe_r,
                            rx_cnt != ZERO};
      `UWM_IDX_MSR: rmux = {mstate, delta_r};
      `UWM_IDX_USR: rmux = {3'b000, rx_cnt == DEPTH, rx_cnt != ZERO, tq_empty,
                            tx_cnt != DEPTH, tx_busy | ~tq_empty | (rs_r != R_IDLE)};
      `UWM_IDX_TFL: rmux = {{(7-AW){1'b0}}, tx_cnt};
      `UWM_IDX_RFL: rmux = {{(7-AW){1'b0}}, rx_cnt};
      default: rmux = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data captured in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 8'h00;
    end else if (setup && !pwrite) begin
      prdata_r <= rmux;
    end
  end

  // Software registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dll_r <= 8'h00;
      dlh_r <= 8'h00;
      ier_r <= 8'h00;
      lcr_r <= `UWM_LCR_RESET;
      mcr_r <= 6'h00;
      fifo_en_r <= 1'b0;
      ttrig_r <= 2'b00;
      rtrig_r <= 2'b00;
    end else if (wr) begin
      case (idx)
        `UWM_IDX_DATA: begin
          if (divsel) begin
            dll_r <= pwdata[7:0];
          end
        end
        `UWM_IDX_IER: begin
          if (divsel) begin
            dlh_r <= pwdata[7:0];
          end else begin
            ier_r <= pwdata[7:0] & 8'h8f;
          end
        end
        `UWM_IDX_FCR: begin
          fifo_en_r <= pwdata[0];
          ttrig_r <= pwdata[5:4];
          rtrig_r <= pwdata[7:6];
        end
        `UWM_IDX_LCR: lcr_r <= pwdata[7:0] & 8'hdf;
        `UWM_IDX_MCR: mcr_r <= pwdata[5:0];
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Baud tick generator, sixteen ticks per bit
  wire [15:0] divisor = {dlh_r, dll_r};
  assign tick = (divisor != 16'h0000) && (bcnt_r >= divisor - 16'h0001);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcnt_r <= 16'h0000;
    end else if (tick || divisor == 16'h0000) begin
      bcnt_r <= 16'h0000;
    end else begin
      bcnt_r <= bcnt_r + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receiver character checks at the stop sample
  wire [1:0] clen = lcr_r[1:0];
  wire pen = lcr_r[`UWM_LCR_PAREN];
  wire [3:0] nrx = {2'b00, clen} + 4'd5 + {3'b000, pen};
  wire [7:0] rdat = rsh_r[7:0] & (8'hff >> (2'd3 - clen));
  wire rpbit = rsh_r[{2'b00, clen} + 4'd5];
  wire rpexp = lcr_r[`UWM_LCR_EVEN] ? ^rdat : ~^rdat;
  wire stop_evt = (rs_r == R_STOP) && tick && (rtc_r == `UWM_TICKS_PER_BIT - 1);
  wire r_fe = ~rx_in;
  wire r_pe = pen & (rpbit != rpexp);
  wire r_bi = ~rx_in & (rdat == 8'h00) & (~pen | ~rpbit);
  assign rx_push = stop_evt & ~rx_full;

  // Receive sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rs_r <= R_IDLE;
      rtc_r <= 4'd0;
      rbit_r <= 4'd0;
      rsh_r <= 9'h000;
      rx_hi_r <= 1'b0;
    end else begin
      case (rs_r)
        R_IDLE: begin
          if (rx_in) begin
            rx_hi_r <= 1'b1;
          end
          if (tick && !rx_in && rx_hi_r) begin
            rs_r <= R_START;
            rtc_r <= 4'd0;
          end
        end
        R_START: begin
          if (tick) begin
            rtc_r <= rtc_r + 4'd1;
            if (rtc_r == `UWM_RX_MID) begin
              rtc_r <= 4'd0;
              rbit_r <= 4'd0;
              rsh_r <= 9'h000;
              rs_r <= rx_in ? R_IDLE : R_BITS;
            end
          end
        end
        R_BITS: begin
          if (tick) begin
            rtc_r <= rtc_r + 4'd1;
            if (rtc_r == `UWM_TICKS_PER_BIT - 1) begin
              rsh_r[rbit_r] <= rx_in;
              rbit_r <= rbit_r + 4'd1;
              if (rbit_r == nrx - 4'd1) begin
                rs_r <= R_STOP;
              end
            end
          end
        end
        R_STOP: begin
          if (tick) begin
            rtc_r <= rtc_r + 4'd1;
            if (rtc_r == `UWM_TICKS_PER_BIT - 1) begin
              rx_hi_r <= rx_in;
              rs_r <= R_IDLE;
            end
          end
        end
        default: rs_r <= R_IDLE;
      endcase
    end
  end

  // Character timeout while data waits unread
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmo_cnt_r <= 10'd0;
      tmo_r <= 1'b0;
    end else if (rx_push || rx_pop || rx_clr || rx_cnt == ZERO) begin
      tmo_cnt_r <= 10'd0;
      tmo_r <= 1'b0;
    end else if (tick) begin
      if (tmo_cnt_r == `UWM_RX_TMO_TICKS - 10'd1) begin
        tmo_r <= 1'b1;
      end else begin
        tmo_cnt_r <= tmo_cnt_r + 10'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Line status flags: a set wins, a read clears only what it reported
  wire lsr_rd = rd && (idx == `UWM_IDX_LSR);
  wire msr_rd = rd && (idx == `UWM_IDX_MSR);
  wire [7:0] lclr = lsr_rd ? prdata_r : 8'h00;
  wire [3:0] mclr = msr_rd ? prdata_r[3:0] : 4'h0;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_r <= 1'b0;
      pe_r <= 1'b0;
      fe_r <= 1'b0;
      bi_r <= 1'b0;
      rx_err_r <= 1'b0;
    end else begin
      oe_r <= (stop_evt & rx_full) | (oe_r & ~lclr[1]);
      pe_r <= (rx_push & r_pe) | (pe_r & ~lclr[2]);
      fe_r <= (rx_push & r_fe) | (fe_r & ~lclr[3]);
      bi_r <= (rx_push & r_bi) | (bi_r & ~lclr[4]);
      rx_err_r <= (rx_push & (r_pe | r_fe | r_bi)) | (rx_err_r & ~lclr[7]);
    end
  end

  // Modem deltas; ring edge is the pin going high
  // First edge after reset only loads the history, so no false delta
  wire [3:0] mchg = {mstate[3] ^ mprev_r[3], mprev_r[2] & ~mstate[2],
                     mstate[1] ^ mprev_r[1], mstate[0] ^ mprev_r[0]};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mprev_r <= 4'h0;
      delta_r <= 4'h0;
      mseen_r <= 1'b0;
    end else begin
      mprev_r <= mstate;
      mseen_r <= 1'b1;
      delta_r <= (mchg & {4{mseen_r}}) | (delta_r & ~mclr);
    end
  end

  // Automatic request to send follows the receive threshold
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rts_flow_r <= 1'b1;
    end else if (rx_cnt == ZERO) begin
      rts_flow_r <= 1'b1;
    end else if (rx_cnt >= rx_lvl) begin
      rts_flow_r <= 1'b0;
    end
  end

  // Pin drivers, inactive high during loopback
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rts_n_r <= 1'b1;
      dtr_n_r <= 1'b1;
      out1_n_r <= 1'b1;
      out2_n_r <= 1'b1;
      sout_r <= 1'b1;
    end else begin
      rts_n_r <= loop | ~(mcr_r[`UWM_REQUEST_TO_SEND_CTL] & (~afce | rts_flow_r));
      dtr_n_r <= loop | ~mcr_r[`UWM_TERMINAL_READY_CTL];
      out1_n_r <= loop | ~mcr_r[`UWM_USER_OUTPUT_ONE];
      out2_n_r <= loop | ~mcr_r[`UWM_USER_OUTPUT_TWO];
      sout_r <= loop | txd;
    end
  end
  assign rts_n = rts_n_r;
  assign dtr_n = dtr_n_r;
  assign out1_n = out1_n_r;
  assign out2_n = out2_n_r;
  assign serial_out_pad = sout_r;

  ////////////////////////////////////////////////////////////////////////
  // Queues and transmitter
  uwm_fifo #(.W(11), .AW(AW)) u_rxq (
    .clk(pclk),
    .rst_n(presetn),
    .clr(rx_clr),
    .push(rx_push),
    .wdata({r_bi, r_fe, r_pe, rdat}),
    .pop(rx_pop),
    .rdata(rx_head),
    .count(rx_cnt)
  );

  uwm_fifo #(.W(8), .AW(AW)) u_txq (
    .clk(pclk),
    .rst_n(presetn),
    .clr(tx_clr),
    .push(tx_push),
    .wdata(pwdata[7:0]),
    .pop(tx_start),
    .rdata(tx_head),
    .count(tx_cnt)
  );

  uwm_tx u_tx (
    .clk(pclk),
    .rst_n(presetn),
    .tick(tick),
    .start(tx_start),
    .data(tx_head),
    .char_len(lcr_r[1:0]),
    .par_en(lcr_r[`UWM_LCR_PAREN]),
    .par_even(lcr_r[`UWM_LCR_EVEN]),
    .stop_long(lcr_r[`UWM_LCR_STOP]),
    .brk(lcr_r[`UWM_LCR_BREAK]),
    .txd(txd),
    .busy(tx_busy)
  );
endmodule
`default_nettype wire

// ===== sim/uwm_chk_assertions.sv
/* Checker on the serial transceiver pins: register reads, modem and pad levels.
   Assumes a bind to uwm_core, one clock pclk, reset presetn active low. */
`default_nettype none
module uwm_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic serial_out_pad,
  input wire logic rts_n,
  input wire logic dtr_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lcr_r, mcr_r;
  wire logic [7:0] idx = paddr[9:2];
  // Shadow copies of line and modem control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lcr_r <= 8'h03;
      mcr_r <= 8'h00;
    end else if (psel && penable && pwrite) begin
      if (idx == 8'h06) lcr_r <= pwdata[7:0];
      if (idx == 8'h08) mcr_r <= pwdata[7:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completing read of one register
  sequence rd_s(int i);
    psel && penable && !pwrite && idx == i;
  endsequence
  unmapped_err_a: assert property (psel && penable && idx > 8'h12 |-> pslverr)
    else $error("unmapped access accepted");
  high_zero_a: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  lcr_read_a: assert property (rd_s(6) |-> prdata[7:0] == lcr_r)
    else $error("line control read wrong");
  mcr_read_a: assert property (rd_s(8) |-> prdata[5:0] == mcr_r[5:0])
    else $error("modem control read wrong");
  rts_inv_a: assert property (mcr_r[5:4] == 2'b00 && $stable(mcr_r) |-> rts_n == !mcr_r[1])
    else $error("request pin not inverted");
  dtr_inv_a: assert property (!mcr_r[4] && $stable(mcr_r) |-> dtr_n == !mcr_r[0])
    else $error("ready pin not inverted");
  loop_pins_a: assert property (mcr_r[4] && $stable(mcr_r) |-> serial_out_pad && rts_n && dtr_n)
    else $error("pins not high in loopback");
  break_low_a: assert property (lcr_r[6] && $past(lcr_r[6], 2) && !mcr_r[4] && !$past(mcr_r[4], 2)
    |-> !serial_out_pad) else $error("break not driving line low");
endmodule
bind uwm_core uwm_chk chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pslverr, .serial_out_pad, .rts_n, .dtr_n);
`default_nettype wire

// ===== sim/uwm_remote.sv
/* Far-end serial port: sends and takes frames, owns the modem inputs.
   Assumes BIT pclk cycles per serial bit. */
`default_nettype none
module uwm_remote #(
  parameter int BIT = 32
) (
  input wire logic pclk,
  input wire logic txd,
  output var logic rxd,
  output var logic cts_n,
  output var logic dsr_n,
  output var logic dcd_n,
  output var logic ri_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Line idles high, peer clear to send
  initial {rxd, cts_n, dsr_n, dcd_n, ri_n} = 5'b10111;
  // Start, data LSB first, optional parity, one stop
  task automatic send(input logic [7:0] d, input logic par_on, pbit);
    logic [10:0] f;
    f = {1'b1, pbit, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      if (i != 9 || par_on) begin
        rxd <= f[i];
        repeat (BIT) @(posedge pclk);
      end
    end
  endtask
  // Waits for a start bit, then samples each bit in its middle
  task automatic recv(output logic [7:0] d, output logic ok);
    logic [8:0] f;
    int n;
    n = 0;
    while (txd !== 1'b0 && n < 4000) begin
      @(posedge pclk);
      n++;
    end
    repeat (BIT / 2) @(posedge pclk);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT) @(posedge pclk);
      f[i] = txd;
    end
    d = f[7:0];
    ok = f[8] === 1'b1 && n < 4000;
  endtask
endmodule
`default_nettype wire

// ===== sim/test_uart_with_modem_control.sv
/* Self-checking bench for the serial transceiver over APB.
   Assumes uwm_core, the uwm_remote far end and the bound checker. */
`default_nettype none
module test_uart_with_modem_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = 32; // Divisor 2
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ok, erb;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] rd, got;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, rxd, txd, cts_n, dsr_n, dcd_n, ri_n, rts_n, dtr_n, out1_n, out2_n;
  int err_total = 0, comparisons = 0;
  uwm_core dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .serial_in(rxd), .serial_out_pad(txd), .cts_n, .dsr_n, .dcd_n,
    .ri_n, .rts_n, .dtr_n, .out1_n, .out2_n);
  uwm_remote #(.BIT(BIT)) remote (.pclk, .txd, .rxd, .cts_n, .dsr_n, .dcd_n, .ri_n);
  initial forever #5 pclk = ~pclk;
  task automatic end_of_test();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string s, input logic [7:0] e, v);
    comparisons++;
    if (v !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", s, e, v);
    end
  endtask
  // One APB transfer; read data and error taken at the completing edge
  task automatic rw(input logic w, input logic [7:0] i, d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      err_total++;
      end_of_test();
    end
    rd = prdata[7:0];
    erb = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rc(input logic [7:0] i, m, e, input string s);
    rw(1'b0, i, 8'h00);
    chk(s, e, rd & m);
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rc(8'h06, 8'hff, 8'h03, "lcr reset");
    rc(8'h04, 8'h0f, 8'h01, "iir idle");
    rc(8'h13, 8'hff, 8'h00, "unmapped read");
    chk("unmapped err", 8'h01, {7'h0, erb});
    rw(1'b1, 8'h02, 8'h0f);
    rw(1'b1, 8'h06, 8'h83);
    rw(1'b1, 8'h00, 8'h02);
    rw(1'b1, 8'h02, 8'h00);
    rc(8'h00, 8'hff, 8'h02, "divisor low");
    rw(1'b1, 8'h06, 8'h03);
    rc(8'h02, 8'h0f, 8'h0f, "irq mask");
    rw(1'b1, 8'h04, 8'h07);
    rw(1'b1, 8'h00, 8'ha5);
    fork
      remote.recv(got, ok);
      rc(8'h0a, 8'h40, 8'h00, "tx idle flag");
    join
    chk("tx char", 8'ha5, got);
    chk("tx stop", 8'h01, {7'h0, ok});
    repeat (BIT) @(posedge pclk);
    rc(8'h0a, 8'h60, 8'h60, "tx drained");
    rc(8'h04, 8'h0f, 8'h02, "iir hold");
    remote.cts_n <= 1'b1;
    rw(1'b1, 8'h08, 8'h20);
    for (int i = 0; i < 33; i++) rw(1'b1, 8'h00, 8'(i));
    rc(8'h10, 8'hff, 8'h20, "tx level");
    rc(8'h0e, 8'h06, 8'h00, "tx full");
    rw(1'b1, 8'h04, 8'h05);
    rc(8'h10, 8'hff, 8'h00, "tx flushed");
    rw(1'b1, 8'h08, 8'h00);
    remote.cts_n <= 1'b0;
    rc(8'h04, 8'h0f, 8'h02, "iir order");
    rc(8'h0c, 8'hf1, 8'h11, "modem lines");
    rc(8'h0c, 8'h01, 8'h00, "delta clear");
    rw(1'b1, 8'h08, 8'h13);
    rc(8'h0c, 8'hf0, 8'h30, "looped lines");
    chk("loop pad", 8'h01, {7'h0, txd});
    rw(1'b1, 8'h08, 8'h17);
    rw(1'b1, 8'h08, 8'h13);
    rc(8'h0c, 8'h04, 8'h04, "ring edge");
    rw(1'b1, 8'h08, 8'h03);
    @(posedge pclk);
    chk("modem pins", 8'h03, {4'h0, rts_n, dtr_n, out1_n, out2_n});
    rw(1'b1, 8'h06, 8'h43);
    repeat (4) @(posedge pclk);
    rw(1'b1, 8'h06, 8'h1b);
    remote.send(8'h3c, 1'b1, 1'b0);
    rc(8'h0a, 8'h05, 8'h01, "rx ready");
    rc(8'h12, 8'hff, 8'h01, "rx level");
    rc(8'h00, 8'hff, 8'h3c, "rx data");
    rc(8'h12, 8'hff, 8'h00, "rx popped");
    remote.send(8'h3c, 1'b1, 1'b1);
    rc(8'h04, 8'h0f, 8'h0c, "iir line");
    rc(8'h0a, 8'h05, 8'h05, "parity flag");
    rc(8'h0a, 8'h04, 8'h00, "parity clear");
    rc(8'h04, 8'h0f, 8'h04, "iir rx data");
    end_of_test();
  end
endmodule
`default_nettype wire
